/* File: hw/fixed_reference_defines.vh */
// Constants for the fixed reference control block
`ifndef FIXED_REFERENCE_DEFINES_VH
`define FIXED_REFERENCE_DEFINES_VH

// ***************************************************************
// Register offsets
// ***************************************************************
`define ADDR_W 4
`define OFF_CONTROL 4'h0
`define OFF_IRQ_STATUS 4'h1
`define OFF_IRQ_ENABLE 4'h2
`define OFF_IRQ_CLEAR 4'h3
`define OFF_REQUEST 4'h4

// ***************************************************************
// Control register fields
// ***************************************************************
`define BIT_REF_EN 7
`define BIT_READY 6
`define BIT_TEMP_EN 5
`define BIT_TEMP_RNG 4
`define CMP_GAIN_HI 3
`define CMP_GAIN_LO 2
`define CNV_GAIN_HI 1
`define CNV_GAIN_LO 0
`define CONTROL_RESET 8'h00

// ***************************************************************
// Gain codes
// ***************************************************************
`define GAIN_OFF 2'h0
`define GAIN_1X 2'h1
`define GAIN_2X 2'h2
`define GAIN_4X 2'h3

// ***************************************************************
// Request condition codes
// ***************************************************************
`define OSC_SEL_INTERNAL 3'h2
`define FREQ_SEL_TOP 3'h0
`define BOR_ALWAYS 2'h3
`define BOR_AWAKE 2'h2
`define BOR_SOFTWARE 2'h1

// ***************************************************************
// Interrupt status bits
// ***************************************************************
`define IRQ_READY_RISE 0
`define IRQ_READY_FALL 1
`define IRQ_W 2

// ***************************************************************
// Timing: stabilisation time in ns and cycles at 25 MHz
// ***************************************************************
`define CLK_PERIOD_NS 40
`define SETTLE_TIME_NS 25000
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W 10

`endif

/* File: hw/gain_buffer_decode.v */
// Decoder of one 2-bit buffer gain select field
`timescale 1ns/10ps
`default_nettype none
`include "fixed_reference_defines.vh"

module gain_buffer_decode (
  // Field
  input wire [1:0] gain_select_in,
  // Decoded controls
  output reg buffer_on_out,
  output reg [2:0] gain_onehot_out
);

  // ***************************************************************
  // Decode: bit0 1x, bit1 2x, bit2 4x, none when off
  // ***************************************************************
  always @* begin
    case (gain_select_in)
      `GAIN_4X: gain_onehot_out = 3'h4;
      `GAIN_2X: gain_onehot_out = 3'h2;
      `GAIN_1X: gain_onehot_out = 3'h1;
      default: gain_onehot_out = 3'h0;
    endcase
    buffer_on_out = (gain_select_in != `GAIN_OFF);
  end

endmodule
`default_nettype wire

/* File: hw/fixed_reference_control.v */
// Control and status logic of the fixed voltage reference
`timescale 1ns/10ps
`default_nettype none
`include "fixed_reference_defines.vh"

module fixed_reference_control #(
  parameter HAS_REGULATOR = 0,
  parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // Register port
  input wire [`ADDR_W-1:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // System conditions
  input wire sleep_in,
  input wire [2:0] osc_select_in,
  input wire [3:0] internal_frequency_select_in,
  input wire [1:0] brownout_mode_select_in,
  input wire brownout_fast_start_in,
  input wire regulator_power_mode_in,
  // Analog controls
  output reg reference_enable_out,
  output reg temp_indicator_enable_out,
  output reg temp_range_select_out,
  output wire comparator_buffer_on_out,
  output wire [2:0] comparator_gain_out,
  output wire converter_buffer_on_out,
  output wire [2:0] converter_gain_out,
  output reg reference_request_out,
  // Interrupt
  output wire irq_out
);

  reg [7:0] control_reg;
  reg [`SETTLE_CNT_W-1:0] settle_reg;
  reg ready_reg;
  reg ready_prev_reg;
  reg [`IRQ_W-1:0] irq_status_reg;
  reg [`IRQ_W-1:0] irq_enable_reg;
  reg [`IRQ_W-1:0] irq_status_next;
  reg request_next;
  wire ready_flag;
  wire [`IRQ_W-1:0] irq_event;
  wire osc_req;
  wire bor_req;
  wire reg_req;

  // ***************************************************************
  // Control register
  // ***************************************************************
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      control_reg <= `CONTROL_RESET;
    end else if (wr_in && addr_in == `OFF_CONTROL) begin
      control_reg <= {wdata_in[7], 1'b0, wdata_in[5:0]};
    end
  end

  // Analog enables follow the stored bits
  always @* begin
    reference_enable_out = control_reg[`BIT_REF_EN];
    temp_indicator_enable_out = control_reg[`BIT_TEMP_EN];
    temp_range_select_out = control_reg[`BIT_TEMP_RNG];
  end

  // ***************************************************************
  // Gain decoders, one per path
  // ***************************************************************
  gain_buffer_decode u_cmp_gain (
    .gain_select_in(control_reg[`CMP_GAIN_HI:`CMP_GAIN_LO]),
    .buffer_on_out(comparator_buffer_on_out),
    .gain_onehot_out(comparator_gain_out)
  );

  gain_buffer_decode u_cnv_gain (
    .gain_select_in(control_reg[`CNV_GAIN_HI:`CNV_GAIN_LO]),
    .buffer_on_out(converter_buffer_on_out),
    .gain_onehot_out(converter_gain_out)
  );

  // ***************************************************************
  // Stabilisation timer; restarts whenever the reference is off
  // ***************************************************************
  always @(posedge ref_clk_in) begin
    if (rst_in || !control_reg[`BIT_REF_EN]) begin
      settle_reg <= {`SETTLE_CNT_W{1'b0}};
      ready_reg <= 1'b0;
    end else if (settle_reg == SETTLE_CYCLES[`SETTLE_CNT_W-1:0] - 1'b1) begin
      ready_reg <= 1'b1;
    end else begin
      settle_reg <= settle_reg + 1'b1;
    end
  end

  // Regulator variant forces ready high; otherwise drops with the enable bit at once
  assign ready_flag = (HAS_REGULATOR != 0) ? 1'b1 :
                      (ready_reg & control_reg[`BIT_REF_EN]);

  // ***************************************************************
  // Reference request from other system blocks
  // ***************************************************************
  assign osc_req = (osc_select_in == `OSC_SEL_INTERNAL) &&
                   (internal_frequency_select_in[3:1] == `FREQ_SEL_TOP) &&
                   !sleep_in;
  assign bor_req = (brownout_mode_select_in == `BOR_ALWAYS) ||
                   (brownout_mode_select_in == `BOR_AWAKE && brownout_fast_start_in &&
                    !sleep_in) ||
                   (brownout_mode_select_in == `BOR_SOFTWARE &&
                    brownout_fast_start_in);
  assign reg_req = regulator_power_mode_in && !sleep_in;

  always @* begin
    request_next = osc_req | bor_req | reg_req;
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      reference_request_out <= 1'b0;
    end else begin
      reference_request_out <= request_next;
    end
  end

  // ***************************************************************
  // Interrupts: ready rise and fall events
  // ***************************************************************
  assign irq_event = {ready_prev_reg & ~ready_flag, ~ready_prev_reg & ready_flag};

  // Set wins over a clear in the same cycle
  always @* begin
    irq_status_next = irq_status_reg;
    if (wr_in && addr_in == `OFF_IRQ_CLEAR) begin
      irq_status_next = irq_status_next & ~wdata_in[`IRQ_W-1:0];
    end
    irq_status_next = irq_status_next | irq_event;
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      ready_prev_reg <= 1'b0;
      irq_status_reg <= {`IRQ_W{1'b0}};
      irq_enable_reg <= {`IRQ_W{1'b0}};
    end else begin
      ready_prev_reg <= ready_flag;
      irq_status_reg <= irq_status_next;
      if (wr_in && addr_in == `OFF_IRQ_ENABLE) begin
        irq_enable_reg <= wdata_in[`IRQ_W-1:0];
      end
    end
  end

  assign irq_out = |(irq_status_reg & irq_enable_reg);

  // ***************************************************************
  // Read data, valid the cycle after the read strobe
  // ***************************************************************
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `OFF_CONTROL: rdata_out <= {control_reg[7], ready_flag, control_reg[5:0]};
        `OFF_IRQ_STATUS: rdata_out <= {{(8-`IRQ_W){1'b0}}, irq_status_reg};
        `OFF_IRQ_ENABLE: rdata_out <= {{(8-`IRQ_W){1'b0}}, irq_enable_reg};
        `OFF_REQUEST: rdata_out <= {7'h00, reference_request_out};
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* File: sim/fixed_reference_control_sva.sv */
// Assertion checker for the fixed reference control block
`timescale 1ns/10ps
`default_nettype none
`include "fixed_reference_defines.vh"
module fixed_reference_control_sva #(
  parameter HAS_REGULATOR = 0
) (
  // Clock, reset and register port
  input wire ref_clk_in,
  input wire rst_in,
  input wire [`ADDR_W-1:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  // Conditions and controls
  input wire sleep_in,
  input wire [2:0] osc_select_in,
  input wire [3:0] internal_frequency_select_in,
  input wire [1:0] brownout_mode_select_in,
  input wire brownout_fast_start_in,
  input wire regulator_power_mode_in,
  input wire reference_enable_out,
  input wire temp_indicator_enable_out,
  input wire temp_range_select_out,
  input wire [2:0] comparator_gain_out,
  input wire [2:0] converter_gain_out,
  input wire reference_request_out
);
  // ***************************************
  // Helpers
  // ***************************************
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire wc = wr_in && addr_in == `OFF_CONTROL;
  wire rc = rd_in && addr_in == `OFF_CONTROL;
  wire [1:0] bm = brownout_mode_select_in;
  wire hf = osc_select_in == 3'h2 && internal_frequency_select_in[3:1] == 3'h0 && !sleep_in;
  wire bor = bm == 2'h3 || (brownout_fast_start_in && (bm == 2'h1 || (bm == 2'h2 && !sleep_in)));
  wire need = hf || bor || (regulator_power_mode_in && !sleep_in);
  function automatic [2:0] dec(input [1:0] g);
    dec = {g == 2'h3, g == 2'h2, g == 2'h1};
  endfunction
  a_enable_write: assert property (wc |=> reference_enable_out == $past(wdata_in[7]))
    else $error("enable wrong after write");
  a_temp_enable: assert property (wc |=> temp_indicator_enable_out == $past(wdata_in[5]))
    else $error("temperature enable wrong");
  a_temp_range: assert property (wc |=> temp_range_select_out == $past(wdata_in[4]))
    else $error("temperature range wrong");
  a_cmp_decode: assert property (wc |=> comparator_gain_out == dec($past(wdata_in[3:2])))
    else $error("comparator gain wrong");
  a_cnv_decode: assert property (wc |=> converter_gain_out == dec($past(wdata_in[1:0])))
    else $error("converter gain wrong");
  a_ready_off: assert property (rc && !reference_enable_out && HAS_REGULATOR == 0 |=> !rdata_out[6])
    else $error("ready set while disabled");
  a_control_readback: assert property (rc |=> {rdata_out[7], rdata_out[5:0]} ==
    $past({reference_enable_out, temp_indicator_enable_out, temp_range_select_out,
    comparator_gain_out[2] | comparator_gain_out[1], comparator_gain_out[2] | comparator_gain_out[0],
    converter_gain_out[2] | converter_gain_out[1], converter_gain_out[2] | converter_gain_out[0]}))
    else $error("control readback wrong");
  a_request_follow: assert property (1'b1 |=> reference_request_out == $past(need))
    else $error("reference request wrong");
endmodule
bind fixed_reference_control fixed_reference_control_sva #(.HAS_REGULATOR(HAS_REGULATOR)) i_sva (.*);
`default_nettype wire

/* File: sim/fixed_reference_control_tb.sv */
// Self-checking testbench for the fixed reference control block
`timescale 1ns/10ps
`default_nettype none
`include "fixed_reference_defines.vh"
module fixed_reference_control_tb;
  // ***************************************
  // Signals and design
  // ***************************************
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0, rd_in = 1'b0, sleep_in = 1'b0, brownout_fast_start_in = 1'b0;
  logic regulator_power_mode_in = 1'b0;
  logic [2:0] osc_select_in = 3'h0;
  logic [3:0] internal_frequency_select_in = 4'h0;
  logic [1:0] brownout_mode_select_in = 2'h0;
  wire [7:0] rdata_out;
  wire reference_enable_out, temp_indicator_enable_out, temp_range_select_out;
  wire comparator_buffer_on_out, converter_buffer_on_out, reference_request_out, irq_out;
  wire [2:0] comparator_gain_out, converter_gain_out;
  integer failures = 0;
  integer num_checks = 0;
  integer i;
  logic [31:0] seed = 32'd75;
  logic [31:0] r;
  logic [7:0] v;
  logic e;
  logic rd_pend = 1'b0;
  logic [7:0] exp_q[$];
  fixed_reference_control #(.SETTLE_CYCLES(4)) i_dut (.*);
  always #20 ref_clk_in = ~ref_clk_in;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function automatic [2:0] onehot(input [1:0] g);
    onehot = {g == 2'h3, g == 2'h2, g == 2'h1};
  endfunction
  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task bus(input logic w, input logic rr, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    wr_in <= w;
    rd_in <= rr;
    addr_in <= a;
    wdata_in <= d;
  endtask
  task rdx(input logic [3:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Read data monitor against queued notes
  always @(posedge ref_clk_in) rd_pend <= rd_in;
  always @(negedge ref_clk_in) if (rd_pend) check("rdata", exp_q.pop_front(), rdata_out);
  // Watchdog
  initial begin
    #400000;
    failures = failures + 1;
    conclude;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rdx(`OFF_CONTROL, 8'h00);
    for (i = 5; i < 16; i = i + 1) rdx(i[3:0], 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      r = rnd();
      v = {2'b01, r[1:0], i[1:0], ~i[1:0]};
      bus(1'b1, 1'b0, `OFF_CONTROL, v);
      rdx(`OFF_CONTROL, v & 8'h3f);
      @(negedge ref_clk_in);
      check("gains", {2'b00, comparator_gain_out, converter_gain_out},
        {2'b00, onehot(i[1:0]), onehot(~i[1:0])});
      check("buffers", {6'h0, comparator_buffer_on_out, converter_buffer_on_out},
        {6'h0, |i[1:0], |(~i[1:0])});
      check("temp", {6'h0, temp_indicator_enable_out, temp_range_select_out}, {6'h0, v[5:4]});
    end
    bus(1'b1, 1'b0, `OFF_IRQ_ENABLE, 8'h03);
    bus(1'b1, 1'b0, `OFF_CONTROL, 8'h8a);
    rdx(`OFF_CONTROL, 8'h8a);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    repeat (6) @(posedge ref_clk_in);
    rdx(`OFF_CONTROL, 8'hca);
    rdx(`OFF_IRQ_STATUS, 8'h01);
    bus(1'b1, 1'b0, `OFF_IRQ_ENABLE, 8'h00);
    @(negedge ref_clk_in);
    check("irq", {7'h0, irq_out}, 8'h01);
    bus(1'b1, 1'b0, `OFF_IRQ_CLEAR, 8'h01);
    @(negedge ref_clk_in);
    check("irq", {7'h0, irq_out}, 8'h00);
    bus(1'b1, 1'b0, `OFF_CONTROL, 8'h00);
    rdx(`OFF_CONTROL, 8'h00);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    rdx(`OFF_IRQ_STATUS, 8'h02);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    for (i = 0; i < 80; i = i + 1) begin
      r = rnd();
      @(posedge ref_clk_in);
      sleep_in <= r[0];
      osc_select_in <= r[1] ? 3'h2 : r[4:2];
      internal_frequency_select_in <= r[5] ? {3'h0, r[6]} : r[10:7];
      brownout_mode_select_in <= r[12:11];
      brownout_fast_start_in <= r[13];
      regulator_power_mode_in <= r[14] & r[15];
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      e = (osc_select_in == 3'h2 && internal_frequency_select_in[3:1] == 3'h0 && !sleep_in);
      e = e || brownout_mode_select_in == 2'h3 || (regulator_power_mode_in && !sleep_in);
      e = e || (brownout_fast_start_in && (brownout_mode_select_in == 2'h1
        || (brownout_mode_select_in == 2'h2 && !sleep_in)));
      check("request", {7'h0, reference_request_out}, {7'h0, e});
    end
    rdx(`OFF_REQUEST, {7'h0, e});
    bus(1'b1, 1'b0, `OFF_CONTROL, 8'hbf);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rdx(`OFF_CONTROL, 8'h00);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    repeat (2) @(posedge ref_clk_in);
    conclude;
  end
endmodule
`default_nettype wire
